// *** logic/agpc_cfg.svh ***
// constants of the agp pad compensation control block
// assumes a 250 MHz clock and 8-bit config offsets
`ifndef AGPC_CFG_SVH
`define AGPC_CFG_SVH

// ====================
// clock and timing
`define AGPC_CLK_PERIOD_NS 4
`define AGPC_CLK_KHZ       250000
`define AGPC_SETTLE_NS     100
`define AGPC_SETTLE_CYC \
   ((`AGPC_SETTLE_NS + `AGPC_CLK_PERIOD_NS - 1) / `AGPC_CLK_PERIOD_NS)
`define AGPC_QUANTUM_MS    400
`define AGPC_QUANTUM_CYC   (`AGPC_QUANTUM_MS * `AGPC_CLK_KHZ)

// ====================
// configuration offsets
`define AGPC_OFS_CFG_STATUS  8'h88
`define AGPC_OFS_AGP_CAPABILITY_STATUS  8'hA4
`define AGPC_OFS_DYN_COMP    8'hB4
`define AGPC_OFS_BYPASS      8'hB8

// ====================
// field positions
`define AGPC_LEVEL_BIT       25
`define AGPC_RATE_LSB        0
`define AGPC_FW_CAP_BIT      4
`define AGPC_DO_COMP_BIT     0
`define AGPC_ALWAYS_BIT      1
`define AGPC_HV_SEL_BIT      5
`define AGPC_QUAD_SUPP_BIT   6
`define AGPC_FW_EN_BIT       7
`define AGPC_QUANTUM_LSB     12
`define AGPC_PD_RB_LSB       24
`define AGPC_PU_RB_LSB       28
`define AGPC_XFER_BYP_BIT    23
`define AGPC_STRB_BYP_BIT    7

// ====================
// reset values and masks
`define AGPC_DYN_COMP_RESET  32'h0000_0000
`define AGPC_DYN_COMP_WMASK  32'h0000_F0E7
`define AGPC_BYPASS_RESET    32'h0000_0000
`define AGPC_BYPASS_WMASK    32'hFF8F_FF8F
`define AGPC_DRIVE_RESET     4'h8
`define AGPC_RATE_QUAD       3'h7
`define AGPC_RATE_DUAL       3'h3

`endif

// *** logic/agpc_comp_engine.sv ***
// successive-approximation search of pull-up and pull-down drive codes
// assumes pad comparators settle within the settle time of a trial code
`timescale 1ns/1ps
`include "agpc_cfg.svh"

module agpc_comp_engine (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                start,
   input  wire logic                cmpPullupWeak,
   input  wire logic                cmpPulldownWeak,
   output agpc_pkg::agpc_drive_t    trialPullup,
   output agpc_pkg::agpc_drive_t    trialPulldown,
   output logic                     done,
   output agpc_pkg::agpc_drive_t    resultPullup,
   output agpc_pkg::agpc_drive_t    resultPulldown
);

   logic       running_reg;
   logic [1:0] bitIdx_reg;
   logic [4:0] settleCnt_reg;
   agpc_pkg::agpc_drive_t keepUp;
   agpc_pkg::agpc_drive_t keepDown;

   // a weak answer keeps the trial bit
   assign keepUp   = cmpPullupWeak ? trialPullup
                   : (trialPullup & ~(4'h1 << bitIdx_reg));
   assign keepDown = cmpPulldownWeak ? trialPulldown
                   : (trialPulldown & ~(4'h1 << bitIdx_reg));

   // ====================
   // search, one bit per settle period, both codes in parallel
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (reset) begin
         running_reg    <= 1'b0;
         bitIdx_reg     <= 2'h3;
         settleCnt_reg  <= 5'h00;
         trialPullup    <= `AGPC_DRIVE_RESET;
         trialPulldown  <= `AGPC_DRIVE_RESET;
         resultPullup   <= `AGPC_DRIVE_RESET;
         resultPulldown <= `AGPC_DRIVE_RESET;
      end else if (start && !running_reg) begin
         running_reg   <= 1'b1;
         bitIdx_reg    <= 2'h3;
         settleCnt_reg <= 5'h00;
         trialPullup   <= 4'h8;
         trialPulldown <= 4'h8;
      end else if (running_reg) begin
         if (settleCnt_reg != 5'(`AGPC_SETTLE_CYC - 1)) begin
            settleCnt_reg <= settleCnt_reg + 5'h01;
         end else begin
            settleCnt_reg <= 5'h00;
            if (bitIdx_reg == 2'h0) begin
               running_reg    <= 1'b0;
               done           <= 1'b1;
               resultPullup   <= keepUp;
               resultPulldown <= keepDown;
               trialPullup    <= keepUp;
               trialPulldown  <= keepDown;
            end else begin
               bitIdx_reg    <= bitIdx_reg - 2'h1;
               trialPullup   <= keepUp | (4'h1 << (bitIdx_reg - 2'h1));
               trialPulldown <= keepDown | (4'h1 << (bitIdx_reg - 2'h1));
            end
         end
      end
   end

endmodule

// *** logic/agpc_pad_comp.sv ***
// agp pad drive compensation control and capability override
// registers on a config-space port (device 0, function 0);
// comparators, pads and the transfer-idle flag sit outside.
//
// Overview of operation
// - two 32-bit config registers, dynamic compensation and bypass, own offsets.
// - periodic drive adjustment runs only when the card selects 1.5-V signalling; single triggers run on either.
// - automatic mode computes drives once or periodically; bypass applies written drives.
// - strobe pads and other pads are bypassed or compensated independently.
// - slew settings come from software fields only, never from compensation.
// - read-only pull-up/pull-down readback shows applied non-strobe compensated drives.
// - periodic enable runs compensation at quantum-count interval, longest 6.4 s.
// - new drive values are applied only while no agp transfer runs.
// - both bypass bits set makes periodic and single-cycle fields ignored.
// - single trigger with 3.3-V select clear runs once, then blocks periodic updates.
// - trigger bit clears at cycle end; software waits for it before enabling.
// - single trigger with 3.3-V select set runs one 3.3-V cycle.
// - signalling-type pin latched at reset, returned in status bit 25.
// - rates 1X, 2X, 4X and fast writes; never 4X on 3.3-V; only the 4X gate follows this, the rate field still reads 111 on 3.3-V.
// - rate field reads 111 after reset, 011 when 4X suppress is set.
// - fast-write capability reads 0 until fast-write enable is set.
`timescale 1ns/1ps
`include "agpc_cfg.svh"

module agpc_pad_comp #(
   parameter int unsigned QUANTUM_CYCLES = `AGPC_QUANTUM_CYC
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                cfgWrite,
   input  wire logic                cfgRead,
   input  wire logic [7:0]          cfgOffset,
   input  wire logic [3:0]          cfgByteEnable,
   input  wire logic [31:0]         cfgWriteData,
   output logic [31:0]              cfgReadData,
   output logic                     cfgReadValid,
   input  wire logic                signalLevelDetectN,
   input  wire logic                agpIdle,
   input  wire logic                cmpPullupWeak,
   input  wire logic                cmpPulldownWeak,
   output agpc_pkg::agpc_drive_t    calTrialPullup,
   output agpc_pkg::agpc_drive_t    calTrialPulldown,
   output logic                     highVoltageCalSelect,
   output agpc_pkg::agpc_drive_t    xferPullupDrive,
   output agpc_pkg::agpc_drive_t    xferPulldownDrive,
   output agpc_pkg::agpc_drive_t    strbPullupDrive,
   output agpc_pkg::agpc_drive_t    strbPulldownDrive,
   output agpc_pkg::agpc_slew_t     xferPullupSlew,
   output agpc_pkg::agpc_slew_t     xferPulldownSlew,
   output agpc_pkg::agpc_slew_t     strbPullupSlew,
   output agpc_pkg::agpc_slew_t     strbPulldownSlew,
   output logic                     quadRateAllowed,
   output logic                     fastWriteEnable
);

   // ====================
   // helpers
   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldValue,
      input logic [31:0] newValue,
      input logic [3:0]  byteEnable,
      input logic [31:0] writeMask
   );
      logic [31:0] merged;
      merged = oldValue;
      for (int i = 0; i < 4; i++) begin
         if (byteEnable[i]) begin
            merged[i*8 +: 8] = newValue[i*8 +: 8];
         end
      end
      return (merged & writeMask) | (oldValue & ~writeMask);
   endfunction

   // ====================
   // state
   logic [31:0]              dynComp_reg;
   logic [31:0]              bypass_reg;
   logic                     levelHigh_reg;
   logic                     updateLock_reg;
   logic                     singleRun_reg;
   agpc_pkg::agpc_state_t    state_reg;
   agpc_pkg::agpc_drive_t    compPullup_reg;
   agpc_pkg::agpc_drive_t    compPulldown_reg;
   agpc_pkg::agpc_drive_t    newPullup_reg;
   agpc_pkg::agpc_drive_t    newPulldown_reg;

   logic                     writeDynComp;
   logic                     writeBypass;
   logic                     xferBypass;
   logic                     strobeBypass;
   logic                     bothBypass;
   logic                     doCompensate;
   logic                     alwaysCompensate;
   logic                     quadRateSuppress;
   logic                     periodicTick;
   logic                     periodicEnable;
   logic                     startSingle;
   logic                     startPeriodic;
   logic                     engineDone;
   logic                     cycleFinish;
   logic [2:0]               rateField;
   agpc_pkg::agpc_drive_t    engPullup;
   agpc_pkg::agpc_drive_t    engPulldown;

   assign writeDynComp     = cfgWrite && cfgOffset == `AGPC_OFS_DYN_COMP;
   assign writeBypass      = cfgWrite && cfgOffset == `AGPC_OFS_BYPASS;
   assign xferBypass       = bypass_reg[`AGPC_XFER_BYP_BIT];
   assign strobeBypass     = bypass_reg[`AGPC_STRB_BYP_BIT];
   assign bothBypass       = xferBypass && strobeBypass;
   assign doCompensate     = dynComp_reg[`AGPC_DO_COMP_BIT];
   assign alwaysCompensate = dynComp_reg[`AGPC_ALWAYS_BIT];
   assign quadRateSuppress = dynComp_reg[`AGPC_QUAD_SUPP_BIT];

   // periodic runs need 1.5-V, no lock and not both groups bypassed
   assign periodicEnable = alwaysCompensate && !levelHigh_reg
                        && !updateLock_reg && !bothBypass;

   assign startSingle   = state_reg == agpc_pkg::ST_IDLE
                       && doCompensate && !bothBypass;
   assign startPeriodic = state_reg == agpc_pkg::ST_IDLE && !doCompensate
                       && periodicTick && periodicEnable;

   // drive update waits for a gap in agp traffic
   assign cycleFinish = state_reg == agpc_pkg::ST_APPLY && agpIdle;

   // ====================
   // signalling-type strap, taken in the clocked reset path
   always_ff @(posedge clk) begin
      if (reset) begin
         levelHigh_reg <= signalLevelDetectN;
      end
   end

   // ====================
   // dynamic compensation register
   // a write in the finishing cycle beats the hardware clear,
   // so a fresh trigger is not lost
   always_ff @(posedge clk) begin
      if (reset) begin
         dynComp_reg <= `AGPC_DYN_COMP_RESET;
      end else if (writeDynComp) begin
         dynComp_reg <= mergeBytes(dynComp_reg, cfgWriteData,
                                   cfgByteEnable, `AGPC_DYN_COMP_WMASK);
      end else if ((singleRun_reg && cycleFinish)
                   || (doCompensate && bothBypass
                       && state_reg == agpc_pkg::ST_IDLE)) begin
         dynComp_reg[`AGPC_DO_COMP_BIT] <= 1'b0;
      end
   end

   // ====================
   // bypass register: bypass drives and all slew settings
   always_ff @(posedge clk) begin
      if (reset) begin
         bypass_reg <= `AGPC_BYPASS_RESET;
      end else if (writeBypass) begin
         bypass_reg <= mergeBytes(bypass_reg, cfgWriteData,
                                  cfgByteEnable, `AGPC_BYPASS_WMASK);
      end
   end

   // ====================
   // compensation sequencer
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg            <= agpc_pkg::ST_IDLE;
         singleRun_reg        <= 1'b0;
         highVoltageCalSelect <= 1'b0;
         newPullup_reg        <= `AGPC_DRIVE_RESET;
         newPulldown_reg      <= `AGPC_DRIVE_RESET;
      end else begin
         unique case (state_reg)
            agpc_pkg::ST_IDLE: begin
               if (startSingle) begin
                  state_reg            <= agpc_pkg::ST_CAL;
                  singleRun_reg        <= 1'b1;
                  highVoltageCalSelect <= dynComp_reg[`AGPC_HV_SEL_BIT];
               end else if (startPeriodic) begin
                  state_reg            <= agpc_pkg::ST_CAL;
                  singleRun_reg        <= 1'b0;
                  highVoltageCalSelect <= 1'b0;
               end
            end
            agpc_pkg::ST_CAL: begin
               if (engineDone) begin
                  state_reg       <= agpc_pkg::ST_APPLY;
                  newPullup_reg   <= engPullup;
                  newPulldown_reg <= engPulldown;
               end
            end
            agpc_pkg::ST_APPLY: begin
               if (agpIdle) begin
                  state_reg     <= agpc_pkg::ST_IDLE;
                  singleRun_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // ====================
   // applied compensation values and update lock
   always_ff @(posedge clk) begin
      if (reset) begin
         compPullup_reg   <= `AGPC_DRIVE_RESET;
         compPulldown_reg <= `AGPC_DRIVE_RESET;
         updateLock_reg   <= 1'b0;
      end else if (cycleFinish) begin
         compPullup_reg   <= newPullup_reg;
         compPulldown_reg <= newPulldown_reg;
         if (singleRun_reg && !highVoltageCalSelect) begin
            updateLock_reg <= 1'b1;
         end
      end
      // otherwise the last completed result is held
   end

   // ====================
   // pad drive and slew outputs
   // strobes share the compensated codes but have their own bypass
   always_ff @(posedge clk) begin
      if (reset) begin
         xferPullupDrive   <= `AGPC_DRIVE_RESET;
         xferPulldownDrive <= `AGPC_DRIVE_RESET;
         strbPullupDrive   <= `AGPC_DRIVE_RESET;
         strbPulldownDrive <= `AGPC_DRIVE_RESET;
      end else begin
         xferPullupDrive   <= xferBypass ? bypass_reg[31:28]
                                         : compPullup_reg;
         xferPulldownDrive <= xferBypass ? bypass_reg[27:24]
                                         : compPulldown_reg;
         strbPullupDrive   <= strobeBypass ? bypass_reg[15:12]
                                           : compPullup_reg;
         strbPulldownDrive <= strobeBypass ? bypass_reg[11:8]
                                           : compPulldown_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         xferPullupSlew   <= 2'h0;
         xferPulldownSlew <= 2'h0;
         strbPullupSlew   <= 2'h0;
         strbPulldownSlew <= 2'h0;
      end else begin
         xferPullupSlew   <= bypass_reg[19:18];
         xferPulldownSlew <= bypass_reg[17:16];
         strbPullupSlew   <= bypass_reg[3:2];
         strbPulldownSlew <= bypass_reg[1:0];
      end
   end

   // ====================
   // capability override
   // status reports 2X when suppressed; the 4X gate also needs 1.5-V
   assign rateField = quadRateSuppress ? `AGPC_RATE_DUAL
                                       : `AGPC_RATE_QUAD;

   always_ff @(posedge clk) begin
      if (reset) begin
         quadRateAllowed <= 1'b0;
         fastWriteEnable <= 1'b0;
      end else begin
         quadRateAllowed <= !quadRateSuppress && !levelHigh_reg;
         fastWriteEnable <= dynComp_reg[`AGPC_FW_EN_BIT];
      end
   end

   // ====================
   // config read port, data one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         cfgReadData  <= 32'h0000_0000;
         cfgReadValid <= 1'b0;
      end else begin
         cfgReadValid <= cfgRead;
         cfgReadData  <= 32'h0000_0000;
         if (cfgRead) begin
            unique case (cfgOffset)
               `AGPC_OFS_CFG_STATUS: begin
                  cfgReadData[`AGPC_LEVEL_BIT] <= levelHigh_reg;
               end
               `AGPC_OFS_AGP_CAPABILITY_STATUS: begin
                  cfgReadData[`AGPC_RATE_LSB +: 3] <= rateField;
                  cfgReadData[`AGPC_FW_CAP_BIT] <=
                     dynComp_reg[`AGPC_FW_EN_BIT];
               end
               `AGPC_OFS_DYN_COMP: begin
                  cfgReadData <= dynComp_reg;
                  cfgReadData[`AGPC_PU_RB_LSB +: 4] <= compPullup_reg;
                  cfgReadData[`AGPC_PD_RB_LSB +: 4] <= compPulldown_reg;
               end
               `AGPC_OFS_BYPASS: begin
                  cfgReadData <= bypass_reg;
               end
               default: begin
                  cfgReadData <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ====================
   // submodules
   agpc_quantum_timer #(
      .QUANTUM_CYCLES (QUANTUM_CYCLES)
   ) quantumTimer (
      .clk         (clk),
      .reset       (reset),
      .enable      (periodicEnable),
      .quantumCode (dynComp_reg[`AGPC_QUANTUM_LSB +: 4]),
      .tick        (periodicTick)
   );

   agpc_comp_engine compEngine (
      .clk             (clk),
      .reset           (reset),
      .start           (startSingle || startPeriodic),
      .cmpPullupWeak   (cmpPullupWeak),
      .cmpPulldownWeak (cmpPulldownWeak),
      .trialPullup     (calTrialPullup),
      .trialPulldown   (calTrialPulldown),
      .done            (engineDone),
      .resultPullup    (engPullup),
      .resultPulldown  (engPulldown)
   );

endmodule

// *** logic/agpc_pkg.sv ***
// types shared by the agp pad compensation control block
// assumes nothing of its surroundings
package agpc_pkg;

   typedef logic [3:0] agpc_drive_t;
   typedef logic [1:0] agpc_slew_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CAL,
      ST_APPLY
   } agpc_state_t;

endpackage

// *** logic/agpc_quantum_timer.sv ***
// interval timer for periodic compensation
// assumes a free-running core clock; long counts shortened by parameter
`timescale 1ns/1ps
`include "agpc_cfg.svh"

module agpc_quantum_timer #(
   parameter int unsigned QUANTUM_CYCLES = `AGPC_QUANTUM_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        enable,
   input  wire logic [3:0]  quantumCode,
   output logic             tick
);

   logic [31:0] unitCnt_reg;
   logic [3:0]  quantaCnt_reg;

   // ====================
   // interval is (code + 1) quanta
   always_ff @(posedge clk) begin
      tick <= 1'b0;
      if (reset || !enable) begin
         unitCnt_reg   <= 32'h0000_0000;
         quantaCnt_reg <= 4'h0;
      end else if (unitCnt_reg == 32'(QUANTUM_CYCLES - 1)) begin
         unitCnt_reg <= 32'h0000_0000;
         if (quantaCnt_reg >= quantumCode) begin
            quantaCnt_reg <= 4'h0;
            tick          <= 1'b1;
         end else begin
            quantaCnt_reg <= quantaCnt_reg + 4'h1;
         end
      end else begin
         unitCnt_reg <= unitCnt_reg + 32'h0000_0001;
      end
   end

endmodule

// *** testbench/agp_pad_compensation_ctrl_tb.sv ***
// self-checking bench for the agp pad compensation control block
// assumes the card model on the far side and a 20-cycle quantum
`timescale 1ns/1ps
`include "agpc_cfg.svh"
module agp_pad_compensation_ctrl_tb;
   logic                  clk = 1'h0, reset = 1'h1, busy = 1'h0;
   logic                  cfgWrite = 1'h0, cfgRead = 1'h0, threeVolt = 1'h0;
   logic                  cfgReadValid, lvlN, agpIdle, upWeak, dnWeak;
   logic                  hvSel, quadOk, fwEn;
   logic [7:0]            cfgOffset = 8'h00;
   logic [3:0]            cfgByteEnable = 4'hF;
   logic [31:0]           cfgWriteData = 32'h0, cfgReadData, rd;
   agpc_pkg::agpc_drive_t trUp, trDn, xUp, xDn, sUp, sDn;
   agpc_pkg::agpc_drive_t tgtUp = 4'hA, tgtDn = 4'h5;
   agpc_pkg::agpc_slew_t  xUpS, xDnS, sUpS, sDnS;
   int                    error_cnt = 0;
   int                    comparisons = 0;
   initial begin
      forever #2 clk = ~clk;
   end
   agpc_pad_comp #(.QUANTUM_CYCLES(20)) u_dut (
      .clk(clk), .reset(reset), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
      .cfgOffset(cfgOffset), .cfgByteEnable(cfgByteEnable),
      .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
      .cfgReadValid(cfgReadValid), .signalLevelDetectN(lvlN),
      .agpIdle(agpIdle), .cmpPullupWeak(upWeak), .cmpPulldownWeak(dnWeak),
      .calTrialPullup(trUp), .calTrialPulldown(trDn),
      .highVoltageCalSelect(hvSel), .xferPullupDrive(xUp),
      .xferPulldownDrive(xDn), .strbPullupDrive(sUp),
      .strbPulldownDrive(sDn), .xferPullupSlew(xUpS),
      .xferPulldownSlew(xDnS), .strbPullupSlew(sUpS),
      .strbPulldownSlew(sDnS), .quadRateAllowed(quadOk),
      .fastWriteEnable(fwEn));
   agpc_card_model u_card (.clk(clk), .threeVolt(threeVolt), .busy(busy),
      .targetUp(tgtUp), .targetDn(tgtDn), .trialUp(trUp), .trialDn(trDn),
      .levelDetectN(lvlN), .agpIdle(agpIdle), .upWeak(upWeak),
      .dnWeak(dnWeak));
   // ====================
   // tasks enter and leave 1 ns after a rising edge
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task do_reset;
      reset = 1'h1;
      tick(10);
      reset = 1'h0;
   endtask
   task automatic cfg_wr(input logic [7:0] ofs, input logic [31:0] d);
      cfgOffset = ofs;
      cfgWriteData = d;
      cfgWrite = 1'h1;
      tick(1);
      cfgWrite = 1'h0;
      tick(1);
   endtask
   // data stands one cycle: take it at once
   task automatic cfg_rd(input logic [7:0] ofs);
      cfgOffset = ofs;
      cfgRead = 1'h1;
      tick(1);
      cfgRead = 1'h0;
      rd = cfgReadData;
      tick(1);
   endtask
   task automatic settle(input agpc_pkg::agpc_drive_t v, input int lim);
      for (int i = 0; i < lim && xUp !== v; i++) tick(1);
   endtask
   task automatic poll_done;
      for (int i = 0; i < 60; i++) begin
         cfg_rd(`AGPC_OFS_DYN_COMP);
         if (rd[0] === 1'h0) break;
      end
      check("trigger cleared", rd[0], 1'h0);
   endtask
   // ====================
   // scenarios
   task t_status;
      cfg_rd(`AGPC_OFS_CFG_STATUS);
      check("quad allowed", quadOk, 1'h1);
      check("level bit", rd[25], 1'h0);
      cfg_rd(`AGPC_OFS_AGP_CAPABILITY_STATUS);
      check("agp_capability_status", rd, 32'h0000_0007);
      cfg_rd(8'h90);
      check("unmapped", rd, 32'h0000_0000);
      cfg_wr(`AGPC_OFS_BYPASS, 32'hFFFF_FFFF);
      cfg_rd(`AGPC_OFS_BYPASS);
      check("bypass reg", rd, `AGPC_BYPASS_WMASK);
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_00C0);
      cfg_wr(`AGPC_OFS_BYPASS, 32'h0000_0000);
      cfg_rd(`AGPC_OFS_AGP_CAPABILITY_STATUS);
      check("suppressed status", rd, 32'h0000_0013);
      check("quad allowed", quadOk, 1'h0);
      check("fast write", fwEn, 1'h1);
   endtask
   task t_periodic;
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0002);
      settle(4'hA, 300);
      check("periodic pull-down", xDn, 4'h5);
      tgtUp = 4'h3;
      tgtDn = 4'hC;
      settle(4'h3, 300);
      check("repeat pull-down", xDn, 4'hC);
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0000);
      tick(250);
      tgtUp = 4'h6;
      tick(400);
      check("held pull-up", xUp, 4'h3);
   endtask
   task t_single;
      cfg_wr(`AGPC_OFS_BYPASS, 32'hA58D_C309);
      tick(2);
      check("bypass drives", {xUp, xDn}, 8'hA5);
      check("slews", {xUpS, xDnS, sUpS, sDnS}, 8'hD9);
      tgtDn = 4'h9;
      busy = 1'h1;
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0001);
      tick(150);
      cfg_rd(`AGPC_OFS_DYN_COMP);
      check("trigger pending", rd[0], 1'h1);
      check("strobe held", {sUp, sDn}, 8'h3C);
      busy = 1'h0;
      poll_done;
      check("readback", rd[31:24], 8'h69);
      tick(2);
      check("strobe comp", {sUp, sDn}, 8'h69);
      check("xfer kept", {xUp, xDn}, 8'hA5);
      check("slews kept", {xUpS, xDnS, sUpS, sDnS}, 8'hD9);
      tgtUp = 4'h4;
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0002);
      tick(400);
      check("locked strobe", {sUp, sDn}, 8'h69);
   endtask
   task t_both;
      cfg_wr(`AGPC_OFS_BYPASS, 32'h2180_4380);
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0001);
      tick(2);
      cfg_rd(`AGPC_OFS_DYN_COMP);
      check("ignored trigger", rd[0], 1'h0);
      tick(150);
      check("both bypassed", {xUp, xDn, sUp, sDn}, 16'h2143);
   endtask
   task t_hv;
      cfg_wr(`AGPC_OFS_BYPASS, 32'h0000_0000);
      tgtDn = 4'hB;
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0021);
      tick(3);
      check("high voltage cal", hvSel, 1'h1);
      poll_done;
      tick(2);
      check("debug cycle drives", {xUp, xDn}, 8'h4B);
   endtask
   task t_strap;
      threeVolt = 1'h1;
      do_reset;
      tick(2);
      cfg_rd(`AGPC_OFS_CFG_STATUS);
      check("level bit", rd[25], 1'h1);
      check("quad on 3.3 V", quadOk, 1'h0);
      cfg_wr(`AGPC_OFS_DYN_COMP, 32'h0000_0002);
      tick(300);
      check("no 3.3 V periodic", xUp, 4'h8);
   endtask
   task results;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      do_reset;
      t_status;
      t_periodic;
      t_single;
      t_both;
      t_hv;
      t_strap;
      results;
   end
   // several times the expected run
   initial begin
      #80000;
      error_cnt++;
      results;
   end
endmodule

// *** testbench/agpc_card_model.sv ***
// card side: signalling strap, transfer activity, comparator pads
// assumes trial codes settle before the block samples the comparators
`timescale 1ns/1ps
module agpc_card_model (
   input  wire logic                  clk,
   input  wire logic                  threeVolt,
   input  wire logic                  busy,
   input  wire agpc_pkg::agpc_drive_t targetUp,
   input  wire agpc_pkg::agpc_drive_t targetDn,
   input  wire agpc_pkg::agpc_drive_t trialUp,
   input  wire agpc_pkg::agpc_drive_t trialDn,
   output logic                       levelDetectN,
   output logic                       agpIdle,
   output logic                       upWeak,
   output logic                       dnWeak
);
   // pin floats high on 3.3 V cards
   assign levelDetectN = threeVolt;
   always_ff @(posedge clk) begin
      agpIdle <= !busy;
   end
   // trial at or below the match point is weak
   assign upWeak = trialUp <= targetUp;
   assign dnWeak = trialDn <= targetDn;
endmodule

// *** testbench/agpc_pad_comp_monitor.sv ***
// port checker of the pad compensation block
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "agpc_cfg.svh"
module agpc_pad_comp_monitor (
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  cfgWrite,
   input wire logic                  cfgRead,
   input wire logic [7:0]            cfgOffset,
   input wire logic [3:0]            cfgByteEnable,
   input wire logic [31:0]           cfgWriteData,
   input wire logic [31:0]           cfgReadData,
   input wire logic                  cfgReadValid,
   input wire logic                  agpIdle,
   input wire agpc_pkg::agpc_drive_t xferPullupDrive,
   input wire logic                  highVoltageCalSelect,
   input wire agpc_pkg::agpc_slew_t  xferPullupSlew,
   input wire agpc_pkg::agpc_slew_t  strbPullupSlew,
   input wire logic                  quadRateAllowed,
   input wire logic                  fastWriteEnable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire b4Wr = cfgWrite && cfgOffset == `AGPC_OFS_DYN_COMP
      && cfgByteEnable[0];
   wire mapped = cfgOffset inside {`AGPC_OFS_CFG_STATUS,
      `AGPC_OFS_AGP_CAPABILITY_STATUS, `AGPC_OFS_DYN_COMP, `AGPC_OFS_BYPASS};
   sequence s_read_answer;
      cfgReadValid;
   endsequence
   sequence s_hv_trigger;
      b4Wr && cfgWriteData[0] && cfgWriteData[5];
   endsequence
   a_read_answer: assert property (cfgRead |=> s_read_answer)
      else $error("no read answer");
   a_no_stray: assert property (!cfgRead |=> !cfgReadValid)
      else $error("stray read valid");
   a_idle_zero: assert property (!cfgReadValid |-> cfgReadData == 0)
      else $error("idle data not zero");
   a_unmapped_zero: assert property (cfgRead && !mapped |=>
      cfgReadData == 0) else $error("unmapped read not zero");
   a_quad_suppress: assert property (b4Wr && cfgWriteData[6] |->
      ##[1:2] !quadRateAllowed) else $error("4X still allowed");
   a_fast_write: assert property (b4Wr && cfgWriteData[7] |->
      ##[1:2] fastWriteEnable) else $error("no fast write");
   a_hold_busy: assert property (!agpIdle && $past(!agpIdle)
      && !$past(cfgWrite) && !$past(cfgWrite, 2)
      |-> $stable(xferPullupDrive)) else $error("drive moved in transfer");
   a_slew_sw_only: assert property (!$past(cfgWrite)
      && !$past(cfgWrite, 2) |-> $stable(xferPullupSlew)
      && $stable(strbPullupSlew)) else $error("slew moved");
   a_hv_start: assert property (s_hv_trigger |->
      ##[1:2] highVoltageCalSelect) else $error("no 3.3 V cycle");
endmodule
bind agpc_pad_comp agpc_pad_comp_monitor u_mon (.*);
